// file: include/adc_ctrl_params.svh
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// register word offsets on the avalon slave (word aligned)
`define OFS_MODE_CTRL 4'h0
`define OFS_INPUT_SEL 4'h1
`define OFS_INT_CTRL 4'h2
`define OFS_CMD 4'h3
`define OFS_CPU_REGS 4'h4
`define OFS_COMPARE 4'h5
`define OFS_RESULT 4'h6
`define OFS_STATUS 4'h7

// field positions
`define MODE_CMP_BIT 3
`define INT_SEL_BIT 2
`define CMD_START_BIT 0
`define CMD_SKIP_BIT 1
`define CMD_LOADCMP_BIT 2
`define CMD_MOVLO_BIT 3
`define CMD_MOVHI_BIT 4
`define CMD_INTACK_BIT 5

// reset values
`define MODE_CTRL_RST 4'h0
`define INPUT_SEL_RST 3'h0
`define INT_CTRL_RST 4'h0

// timing in machine cycles
`define CONV_CYCLES 62
`define CMP_CYCLES 8
`define CONV_BITS 10

`endif

// file: include/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CMP} phase_e;
  typedef logic [9:0] result_t;
endpackage

// file: logic/mcycle_tick.sv
// machine-cycle strobe: one clk pulse every DIV clocks
module mcycle_tick #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic restart,
  output logic tick
);
  logic [7:0] cnt_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= 8'h00;
      tick <= 1'b0;
    end
    else if (restart)
    begin
      // realign so the first machine cycle after a start is a whole one
      cnt_ff <= (DIV == 1) ? 8'h00 : 8'h01;
      tick <= (DIV == 1);
    end
    else
    begin
      tick <= (cnt_ff == 8'(DIV - 1));
      if (cnt_ff == 8'(DIV - 1))
        cnt_ff <= 8'h00;
      else
        cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule

// file: logic/sar_adc_comparator_control.sv
`include "adc_ctrl_params.svh"
// How it works
// - conversion start loads result register with msb set, rest clear
// - ten trials, msb down to bit zero
// - keep bit when dac below input
// - conversion ends 62 machine cycles after start
// - done sets flag; interrupt request only when int ctrl bit 2 is set
// - mode bit 3 high selects comparator
// - load: aux high nibble, acc low
// - compare register kept across modes
// - compare register access only in comparator mode
// - comparator dac code is compare register
// - comparator flag set when input below dac
// - int ctrl bit picks interrupt or skip
// - flag cleared by interrupt or skip
// - comparison ends 8 machine cycles after start
// - low move: two lsbs to acc top
// - high move: top nibble aux, middle acc
// - flag may spuriously set; skip clears it
// - mode bit 3 low selects conversion
// - conversion dac code is result register
// - three-bit select picks one of eight inputs
module sar_adc_comparator_control #(
  parameter int MCYC_DIV = 4,
  parameter int CONV_CYC = `CONV_CYCLES,
  parameter int CMP_CYC = `CMP_CYCLES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CMP_IN_ABOVE,
  output logic [9:0] DAC_CODE,
  output logic DAC_WIDE,
  output logic [2:0] ANALOG_INPUT_SEL,
  output logic CONV_IRQ,
  output logic BUSY
);
  logic tick;
  logic cmp_s1_ff, cmp_s2_ff, cmp_s3_ff, cmp_ff;
  logic [3:0] mode_ff;
  logic [2:0] sel_ff;
  logic [3:0] intc_ff;
  logic [3:0] acc_ff, aux_ff;
  logic [7:0] compare_ff;
  adc_ctrl_pkg::result_t result_ff;
  adc_ctrl_pkg::phase_e phase_ff;
  logic [6:0] cyc_ff;
  logic [3:0] bit_ff;
  logic flag_ff;
  logic ack_ff;
  logic wr_go, rd_go;
  logic cmd_start, cmd_skip, cmd_intack;
  logic conv_done, cmp_done, set_flag, clr_flag;
  logic trial_edge;
  logic [31:0] nxt_rdata;

  // a free-running divider would make the window up to one machine cycle short
  mcycle_tick #(.DIV(MCYC_DIV)) u_tick (.clk(CLK), .arst_n(ARST_N), .restart(cmd_start), .tick(tick));

  // byte lane 0 enables every register write
  function automatic logic hit(input logic [3:0] ofs);
    hit = wr_go && (AVS_ADDRESS == ofs) && AVS_BYTEENABLE[0];
  endfunction

  function automatic logic is_cmp_mode(input logic [3:0] m);
    is_cmp_mode = m[`MODE_CMP_BIT];
  endfunction

  // one wait cycle per access, answer on the second edge
  assign wr_go = AVS_WRITE && !ack_ff;
  assign rd_go = AVS_READ && !ack_ff;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ack_ff <= 1'b0;
    else
      ack_ff <= (AVS_READ || AVS_WRITE) && !ack_ff;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_ff);
  end

  // comparator output from the analog side: three stages, agree on last two
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      cmp_s3_ff <= 1'b0;
      cmp_ff <= 1'b0;
    end
    else
    begin
      cmp_s1_ff <= CMP_IN_ABOVE;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_s3_ff <= cmp_s2_ff;
      if (cmp_s2_ff == cmp_s3_ff)
        cmp_ff <= cmp_s3_ff;
    end
  end

  // process form so the bus signals read inside hit() are in the sensitivity
  always_comb
  begin
    cmd_start = hit(`OFS_CMD) && AVS_WRITEDATA[`CMD_START_BIT] && (phase_ff == adc_ctrl_pkg::ST_IDLE);
    cmd_skip = hit(`OFS_CMD) && AVS_WRITEDATA[`CMD_SKIP_BIT];
    cmd_intack = hit(`OFS_CMD) && AVS_WRITEDATA[`CMD_INTACK_BIT];
  end

  // mode writes ignored while busy protects the running trial
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mode_ff <= `MODE_CTRL_RST;
      sel_ff <= `INPUT_SEL_RST;
      intc_ff <= `INT_CTRL_RST;
    end
    else
    begin
      if (hit(`OFS_MODE_CTRL) && phase_ff == adc_ctrl_pkg::ST_IDLE)
        mode_ff <= AVS_WRITEDATA[3:0];
      if (hit(`OFS_INPUT_SEL))
        sel_ff <= AVS_WRITEDATA[2:0];
      if (hit(`OFS_INT_CTRL))
        intc_ff <= AVS_WRITEDATA[3:0];
    end
  end

  // cpu working registers a and b; moves from the result land here
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      acc_ff <= 4'h0;
      aux_ff <= 4'h0;
    end
    else if (hit(`OFS_CMD) && AVS_WRITEDATA[`CMD_MOVLO_BIT])
      acc_ff <= {result_ff[1:0], 2'b00};
    else if (hit(`OFS_CMD) && AVS_WRITEDATA[`CMD_MOVHI_BIT])
    begin
      aux_ff <= result_ff[9:6];
      acc_ff <= result_ff[5:2];
    end
    else if (hit(`OFS_CPU_REGS))
    begin
      acc_ff <= AVS_WRITEDATA[3:0];
      aux_ff <= AVS_WRITEDATA[7:4];
    end
  end

  // compare register survives mode changes
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      compare_ff <= 8'h00;
    else if (hit(`OFS_CMD) && AVS_WRITEDATA[`CMD_LOADCMP_BIT] && is_cmp_mode(mode_ff))
      compare_ff <= {aux_ff, acc_ff};
  end

  // trial latched at the end of every sixth machine cycle of the window, at cyc_ff 2, 8, ..., 56
  assign trial_edge = tick && (phase_ff == adc_ctrl_pkg::ST_CONV)
    && (cyc_ff != 7'h00) && ((7'(CONV_CYC) - cyc_ff) % 7'(CONV_CYC / `CONV_BITS) == 7'h00)
    && (bit_ff != 4'hf);
  assign conv_done = tick && (phase_ff == adc_ctrl_pkg::ST_CONV) && (cyc_ff == 7'(CONV_CYC - 1));
  assign cmp_done = tick && (phase_ff == adc_ctrl_pkg::ST_CMP) && (cyc_ff == 7'(CMP_CYC - 1));

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      phase_ff <= adc_ctrl_pkg::ST_IDLE;
      cyc_ff <= 7'h00;
    end
    else if (cmd_start)
    begin
      phase_ff <= is_cmp_mode(mode_ff) ? adc_ctrl_pkg::ST_CMP : adc_ctrl_pkg::ST_CONV;
      cyc_ff <= 7'h00;
    end
    else if (conv_done || cmp_done)
      phase_ff <= adc_ctrl_pkg::ST_IDLE;
    else if (tick && phase_ff != adc_ctrl_pkg::ST_IDLE)
      cyc_ff <= cyc_ff + 7'h01;
  end

  // successive approximation; bit_ff counts down, 4'hf means all done
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      result_ff <= 10'h000;
      bit_ff <= 4'hf;
    end
    else if (cmd_start && !is_cmp_mode(mode_ff))
    begin
      result_ff <= 10'h200;
      bit_ff <= 4'h9;
    end
    else if (trial_edge)
    begin
      if (cmp_ff)
        result_ff[bit_ff] <= 1'b0;
      if (bit_ff != 4'h0)
        result_ff[bit_ff - 4'h1] <= 1'b1;
      bit_ff <= bit_ff - 4'h1;
    end
  end

  // dac above input (cmp_ff) means input below comparison voltage
  assign set_flag = conv_done || (cmp_done && cmp_ff);
  assign clr_flag = (cmd_skip && flag_ff && !intc_ff[`INT_SEL_BIT])
    || (cmd_intack && intc_ff[`INT_SEL_BIT]);

  // set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      flag_ff <= 1'b0;
    else if (set_flag)
      flag_ff <= 1'b1;
    else if (clr_flag)
      flag_ff <= 1'b0;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      CONV_IRQ <= 1'b0;
      DAC_CODE <= 10'h000;
      DAC_WIDE <= 1'b1;
      ANALOG_INPUT_SEL <= 3'h0;
      BUSY <= 1'b0;
    end
    else
    begin
      CONV_IRQ <= (set_flag || (flag_ff && !clr_flag)) && intc_ff[`INT_SEL_BIT];
      DAC_CODE <= is_cmp_mode(mode_ff) ? {compare_ff, 2'b00} : result_ff;
      DAC_WIDE <= !is_cmp_mode(mode_ff);
      ANALOG_INPUT_SEL <= sel_ff;
      BUSY <= (phase_ff != adc_ctrl_pkg::ST_IDLE) && !conv_done && !cmp_done || cmd_start;
    end
  end

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      `OFS_MODE_CTRL: nxt_rdata[3:0] = mode_ff;
      `OFS_INPUT_SEL: nxt_rdata[2:0] = sel_ff;
      `OFS_INT_CTRL: nxt_rdata[3:0] = intc_ff;
      `OFS_CPU_REGS: nxt_rdata[7:0] = {aux_ff, acc_ff};
      `OFS_COMPARE: nxt_rdata[7:0] = is_cmp_mode(mode_ff) ? compare_ff : 8'h00;
      `OFS_RESULT: nxt_rdata[9:0] = result_ff;
      `OFS_STATUS: nxt_rdata[2:0] = {cmp_ff, phase_ff != adc_ctrl_pkg::ST_IDLE, flag_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      AVS_READDATA <= 32'h0000_0000;
    else if (rd_go)
      AVS_READDATA <= nxt_rdata;
  end
endmodule

// file: tb/adc_ctrl_chk.sv
module adc_ctrl_chk #(
  parameter int MCYC_DIV = 4,
  parameter int CONV_CYC = 62,
  parameter int CMP_CYC = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [9:0] DAC_CODE,
  input wire logic DAC_WIDE,
  input wire logic [2:0] ANALOG_INPUT_SEL,
  input wire logic BUSY
);
  int busy_cnt_ff;
  logic wr_ok;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && !BUSY;
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= BUSY ? busy_cnt_ff + 1 : 0;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_conv_len: assert property ($fell(BUSY) && DAC_WIDE |-> busy_cnt_ff == CONV_CYC * MCYC_DIV) else $error("conv len");
  a_cmp_len: assert property ($fell(BUSY) && !DAC_WIDE |-> busy_cnt_ff == CMP_CYC * MCYC_DIV) else $error("cmp len");
  a_start_clear: assert property ($rose(BUSY) && DAC_WIDE |-> ##[0:1] DAC_CODE[8:0] == 9'h000) else $error("no clear");
  a_cmp_dac_low: assert property (!DAC_WIDE |-> DAC_CODE[1:0] == 2'h0) else $error("cmp dac");
  a_cmp_dac_hold: assert property (BUSY && $past(BUSY) && !DAC_WIDE |-> $stable(DAC_CODE)) else $error("dac moved");
  a_mode_write: assert property (wr_ok && !$past(BUSY) && AVS_ADDRESS == 4'h0
    |-> ##1 DAC_WIDE == !$past(AVS_WRITEDATA[3])) else $error("mode bit");
  a_sel_write: assert property (wr_ok && AVS_ADDRESS == 4'h1
    |-> ##1 ANALOG_INPUT_SEL == $past(AVS_WRITEDATA[2:0])) else $error("input sel");
  a_mode_steady: assert property (BUSY && $past(BUSY) |-> $stable(DAC_WIDE)) else $error("mode moved");
  c_conv: cover property ($fell(BUSY) && DAC_WIDE);
  c_cmp: cover property ($fell(BUSY) && !DAC_WIDE);
  c_mode: cover property (wr_ok && AVS_ADDRESS == 4'h0);
endmodule
bind sar_adc_comparator_control adc_ctrl_chk #(
  .MCYC_DIV(MCYC_DIV),
  .CONV_CYC(CONV_CYC),
  .CMP_CYC(CMP_CYC)
) u_chk (
  .CLK(CLK),
  .ARST_N(ARST_N),
  .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .DAC_CODE(DAC_CODE),
  .DAC_WIDE(DAC_WIDE),
  .ANALOG_INPUT_SEL(ANALOG_INPUT_SEL),
  .BUSY(BUSY)
);

// file: tb/analog_src.sv
module analog_src (
  input wire logic [9:0] dac_code,
  input wire logic [2:0] sel,
  input wire logic [79:0] lvl,
  output logic above
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins serve only as analog inputs here; their port latches stay high
  // both modes land on 1/1024 steps; comparator code arrives as {n,2'b00}
  assign above = dac_code > lvl[sel * 10 +: 10];
endmodule

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [2:0] s; logic [9:0] v; logic [9:0] e;} row_s;
  row_s rows [5] = '{'{3'h0, 10'h000, 10'h000}, '{3'h7, 10'h3ff, 10'h3ff},
    '{3'h3, 10'h200, 10'h200}, '{3'h5, 10'h1ff, 10'h1ff}, '{3'h2, 10'h155, 10'h155}};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [79:0] lvl = 80'h0;
  logic [31:0] rdata, q;
  logic [9:0] dac;
  logic [2:0] sel;
  logic wait_rq, above, wide, irq, busy;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  sar_adc_comparator_control #(.MCYC_DIV(2)) u_dut (
    .CLK(clk),
    .ARST_N(arst_n),
    .AVS_ADDRESS(adr),
    .AVS_READ(rd),
    .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_rq),
    .CMP_IN_ABOVE(above),
    .DAC_CODE(dac),
    .DAC_WIDE(wide),
    .ANALOG_INPUT_SEL(sel),
    .CONV_IRQ(irq),
    .BUSY(busy)
  );
  analog_src u_src (.dac_code(dac), .sel(sel), .lvl(lvl), .above(above));
  task automatic results;
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wait_rq !== 1'b0)
      @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(q, e, nm);
  endtask
  // no fixed wait: a stuck busy is left to the cycle ceiling
  task automatic run;
    bus(1'b1, 4'h3, 32'h1);
    repeat (3) @(posedge clk);
    while (busy === 1'b1)
      @(posedge clk);
    @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(wait_rq, 1, "waitrequest");
    chk(wide, 1, "wide");
    foreach (rows[i])
    begin
      lvl[rows[i].s * 10 +: 10] = rows[i].v;
      bus(1'b1, 4'h1, rows[i].s);
      run();
      rdchk(4'h7, 1, "flag");
      rdchk(4'h6, rows[i].e, "result");
      bus(1'b1, 4'h3, 32'h10);
      rdchk(4'h4, rows[i].e[9:2], "move high");
      bus(1'b1, 4'h3, 32'h8);
      rdchk(4'h4, {rows[i].e[9:6], rows[i].e[1:0], 2'b00}, "move low");
      bus(1'b1, 4'h3, 32'h2);
      rdchk(4'h7, 0, "skip");
    end
    bus(1'b1, 4'h2, 32'h4);
    run();
    chk(irq, 1, "irq");
    bus(1'b1, 4'h3, 32'h20);
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq ack");
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'h8);
    bus(1'b1, 4'h4, 32'h5a);
    bus(1'b1, 4'h3, 32'h4);
    chk(wide, 0, "wide");
    rdchk(4'h5, 32'h5a, "compare");
    chk(dac, 10'h168, "dac");
    lvl[29:20] = 10'h167;
    run();
    rdchk(4'h7, 5, "below");
    lvl[29:20] = 10'h168;
    run();
    rdchk(4'h7, 1, "equal");
    bus(1'b1, 4'h3, 32'h2);
    rdchk(4'h7, 0, "cmp skip");
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h3, 32'h2);
    rdchk(4'h7, 0, "back");
    rdchk(4'h5, 0, "hidden");
    bus(1'b1, 4'h0, 32'h8);
    rdchk(4'h5, 32'h5a, "kept");
    rdchk(4'hc, 0, "unmapped");
    results();
  end
endmodule
